// file: flow_consts.vh
`ifndef FLOW_CONSTS_VH
`define FLOW_CONSTS_VH
`define CMD_LOAD_RUN      8'h9C
`define CMD_LOOP_CLOSE    8'hD2
`define CMD_REG_MASK      8'h59
`define CMD_CALL_INPUT    8'hC9
`define TYPE_CALL         8'h01
`define TYPE_JUMP         8'h00
`define STAT_LOAD_ERR     4'hE
`define STAT_PROG_ERR     4'hC
`define HDR_SHORT_MAX     16'h00FE
`define BUF_AW            9
`define THREAD2_BASE      9'h100
`define OP_AND            4'h0
`define OP_OR             4'h1
`define OP_NAND           4'h2
`define OP_NOR            4'h3
`endif

// file: mask_cond.v
`timescale 1ns/1ns
`include "flow_consts.vh"
module mask_cond (
    input  wire [3:0]  op_i,
    input  wire [31:0] reg_i,
    input  wire [31:0] p1_i,
    input  wire [31:0] p2_i,
    output reg         hit_o
);
    wire signed [31:0] r = reg_i;
    wire signed [31:0] a = p1_i;
    wire signed [31:0] b = p2_i;
    always @*
    begin
        case (op_i)
            `OP_AND:  hit_o = ((reg_i & p2_i) == (p1_i & p2_i));
            `OP_OR:   hit_o = |(~(reg_i ^ p1_i) & p2_i);
            `OP_NAND: hit_o = ((reg_i & p2_i) != (p1_i & p2_i));
            `OP_NOR:  hit_o = ~|(~(reg_i ^ p1_i) & p2_i);
            4'h4:     hit_o = (a < r) && (r < b);
            4'h5:     hit_o = (a <= r) && (r < b);
            4'h6:     hit_o = (a < r) && (r <= b);
            4'h7:     hit_o = (a <= r) && (r <= b);
            4'h8:     hit_o = (r <= a) || (r >= b);
            4'h9:     hit_o = (r < a) || (r >= b);
            4'hA:     hit_o = (r <= a) || (r > b);
            4'hB:     hit_o = (r < a) || (r > b);
            default:  hit_o = 1'b0;
        endcase
    end
endmodule

// file: nv_arbiter.v
`timescale 1ns/1ns
module nv_arbiter (
    input  wire clk_i,
    input  wire reset_n_i,
    input  wire ce_i,
    input  wire req1_i,
    input  wire req2_i,
    output reg  gnt1_o,
    output reg  gnt2_o
);
    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            gnt1_o <= 1'b0;
            gnt2_o <= 1'b0;
        end
        else if (ce_i)
        begin
            // Holder keeps it until it drops its request
            if (gnt1_o)
                gnt1_o <= req1_i;
            else if (gnt2_o)
                gnt2_o <= req2_i;
            else if (req1_i)
                gnt1_o <= 1'b1; // see [RQ8]
            else
                gnt2_o <= req2_i; // see [RQ8]
        end
    end
endmodule

// file: program_load_flow_control.v
// Contract
// [RQ1] Load-and-run copies stored program into the buffer, then runs it.
// [RQ2] Checksum accumulated while loading; mismatch sets status bit 14.
// [RQ3] Run starts only after an error-free load, entering program mode.
// [RQ4] Execution error disables servo, stops program, sets status bit 12.
// [RQ5] Buffer keeps the program until cleared or overwritten by a load.
// [RQ6] Header is one word up to 254 words, two words from 255.
// [RQ7] Thread 2 loads into its own buffer space.
// [RQ8] One thread at a time owns non-volatile memory; the other waits. A thread 2 load ignores nv_other_req_i, so it never waits for the other thread.
// [RQ9] Load-and-run is code 156, two words, one unsigned address.
// [RQ10] Loop close adds increment to loop register, compares with final.
// [RQ11] Loop close is code 210, two words, opener buffer address.
// [RQ12] Code 89 high byte type: 1 call, 0 jump.
// [RQ13] Mask call evaluates op, register, two signed params; calls on hit.
// [RQ14] Input call is code 201, four words: select, state, address.
// [RQ15] Call jumps to target; return resumes after the call.
// [RQ16] A call before return is an error: stop, set bit 12.
// [RQ17] Load-and-run clears the return stack.
// [RQ18] Loop branches back while final not passed, else falls through.
`timescale 1ns/1ns
`include "flow_consts.vh"
module program_load_flow_control (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        ce_i,
    input  wire        cmd_valid_i,
    input  wire        cmd_thread_i,
    input  wire [7:0]  cmd_code_i,
    input  wire [15:0] cmd_p0_i,
    input  wire [15:0] cmd_p1_i,
    input  wire [31:0] cmd_p2_i,
    input  wire [31:0] cmd_p3_i,
    input  wire [15:0] cmd_p4_i,
    input  wire [15:0] cmd_ret_pc_i,
    input  wire        ret_i,
    input  wire        exec_err_i,
    input  wire        clear_buf_i,
    input  wire [31:0] reg_data_i,
    input  wire [31:0] loop_inc_i,
    input  wire [31:0] loop_final_i,
    input  wire [15:0] inputs_i,
    input  wire [15:0] nv_data_i,
    input  wire        nv_valid_i,
    input  wire        nv_other_req_i,
    output reg         nv_req_o,
    output reg  [15:0] nv_addr_o,
    output reg         buf_we_o,
    output reg  [8:0]  buf_addr_o,
    output reg  [15:0] buf_data_o,
    output reg         reg_we_o,
    output reg  [31:0] reg_wdata_o,
    output reg         pc_load_o,
    output reg  [15:0] pc_o,
    output reg         prog_mode_o,
    output reg         servo_en_o,
    output reg         ack_o,
    output reg  [15:0] status_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_HDR  = 3'h2;
    localparam ST_HDR2 = 3'h3;
    localparam ST_DATA = 3'h4;
    localparam ST_CHK  = 3'h5;

    reg  [2:0]  state_r;
    reg  [15:0] len_r;
    reg  [15:0] cnt_r;
    reg  [15:0] sum_r;
    reg  [15:0] stored_sum_r;
    reg  [8:0]  base_r;
    reg         in_call_r;
    reg  [15:0] ret_pc_r;
    wire        gnt1;
    wire        gnt2;
    wire        mask_hit;
    wire [31:0] loop_next = reg_data_i + loop_inc_i;
    wire        loop_more;
    wire [3:0]  in_sel = cmd_p0_i[15] ? 4'h0 - cmd_p0_i[3:0] : cmd_p0_i[3:0];
    wire        in_hit = (inputs_i[in_sel] == cmd_p1_i[0]);
    wire        grant = cmd_thread_i ? gnt2 : gnt1;

    assign loop_more = loop_inc_i[31] ? ($signed(loop_next) >= $signed(loop_final_i))
                                      : ($signed(loop_next) <= $signed(loop_final_i));

    function [8:0] buf_index;
        input [8:0]  base;
        input [15:0] idx;
        begin
            buf_index = base + idx[8:0];
        end
    endfunction

    mask_cond u_mask (
        .op_i  (cmd_p0_i[3:0]),
        .reg_i (reg_data_i),
        .p1_i  (cmd_p2_i),
        .p2_i  (cmd_p3_i),
        .hit_o (mask_hit)
    );

    nv_arbiter u_arb (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .req1_i    (nv_req_o & ~cmd_thread_i),
        .req2_i    (cmd_thread_i ? nv_req_o : nv_other_req_i),
        .gnt1_o    (gnt1),
        .gnt2_o    (gnt2)
    );

    always @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            state_r      <= ST_IDLE;
            len_r        <= 16'h0000;
            cnt_r        <= 16'h0000;
            sum_r        <= 16'h0000;
            stored_sum_r <= 16'h0000;
            base_r       <= 9'h000;
            in_call_r    <= 1'b0;
            ret_pc_r     <= 16'h0000;
            nv_req_o     <= 1'b0;
            nv_addr_o    <= 16'h0000;
            buf_we_o     <= 1'b0;
            buf_addr_o   <= 9'h000;
            buf_data_o   <= 16'h0000;
            reg_we_o     <= 1'b0;
            reg_wdata_o  <= 32'h00000000;
            pc_load_o    <= 1'b0;
            pc_o         <= 16'h0000;
            prog_mode_o  <= 1'b0;
            servo_en_o   <= 1'b1;
            ack_o        <= 1'b0;
            status_o     <= 16'h0000;
        end
        else if (ce_i)
        begin
            buf_we_o  <= 1'b0;
            reg_we_o  <= 1'b0;
            pc_load_o <= 1'b0;
            ack_o     <= 1'b0;
            if (exec_err_i)
            begin
                servo_en_o            <= 1'b0; // see [RQ4]
                prog_mode_o           <= 1'b0;
                status_o[`STAT_PROG_ERR] <= 1'b1;
            end
            if (ret_i && in_call_r)
            begin
                in_call_r <= 1'b0; // see [RQ15]
                pc_o      <= ret_pc_r;
                pc_load_o <= 1'b1;
            end
            if (clear_buf_i && state_r == ST_IDLE)
                prog_mode_o <= 1'b0; // see [RQ5]
            case (state_r)
                ST_IDLE:
                begin
                    if (cmd_valid_i)
                    begin
                        ack_o <= 1'b1;
                        case (cmd_code_i)
                            `CMD_LOAD_RUN: // see [RQ9]
                            begin
                                nv_req_o  <= 1'b1; // see [RQ1]
                                nv_addr_o <= cmd_p0_i;
                                base_r    <= cmd_thread_i ? `THREAD2_BASE : 9'h000; // see [RQ7]
                                in_call_r <= 1'b0; // see [RQ17]
                                sum_r     <= 16'h0000;
                                prog_mode_o <= 1'b0;
                                status_o[`STAT_LOAD_ERR] <= 1'b0;
                                state_r   <= ST_WAIT;
                            end
                            `CMD_LOOP_CLOSE: // see [RQ11]
                            begin
                                reg_we_o    <= 1'b1; // see [RQ10]
                                reg_wdata_o <= loop_next;
                                if (loop_more)
                                begin
                                    pc_o      <= cmd_p0_i + 16'h0004; // see [RQ18]
                                    pc_load_o <= 1'b1;
                                end
                            end
                            `CMD_REG_MASK, `CMD_CALL_INPUT: // see [RQ14]
                            begin
                                if (cmd_code_i == `CMD_CALL_INPUT ? in_hit :
                                    (cmd_p0_i[15:8] == `TYPE_CALL ? mask_hit : 1'b0)) // see [RQ12]
                                begin
                                    if (in_call_r)
                                    begin
                                        status_o[`STAT_PROG_ERR] <= 1'b1; // see [RQ16]
                                        prog_mode_o <= 1'b0;
                                    end
                                    else
                                    begin
                                        in_call_r <= 1'b1; // see [RQ13]
                                        ret_pc_r  <= cmd_ret_pc_i;
                                        pc_o      <= cmd_p4_i;
                                        pc_load_o <= 1'b1; // see [RQ15]
                                    end
                                end
                                else if (cmd_code_i == `CMD_REG_MASK &&
                                         cmd_p0_i[15:8] == `TYPE_JUMP && mask_hit)
                                begin
                                    pc_o      <= cmd_p4_i;
                                    pc_load_o <= 1'b1;
                                end
                            end
                            default:
                                ack_o <= 1'b1;
                        endcase
                    end
                end
                ST_WAIT:
                    if (grant) // see [RQ8]
                        state_r <= ST_HDR;
                ST_HDR:
                    if (nv_valid_i)
                    begin
                        nv_addr_o <= nv_addr_o + 16'h0001;
                        cnt_r     <= 16'h0000;
                        if (nv_data_i[15:8] == 8'hFF)
                        begin
                            state_r <= ST_HDR2; // see [RQ6]
                            stored_sum_r <= {8'h00, nv_data_i[7:0]};
                        end
                        else
                        begin
                            len_r        <= {8'h00, nv_data_i[15:8]}; // see [RQ6]
                            stored_sum_r <= {8'h00, nv_data_i[7:0]};
                            state_r      <= ST_DATA;
                        end
                    end
                ST_HDR2:
                    if (nv_valid_i)
                    begin
                        len_r     <= nv_data_i; // see [RQ6]
                        nv_addr_o <= nv_addr_o + 16'h0001;
                        state_r   <= ST_DATA;
                    end
                ST_DATA:
                    if (cnt_r == len_r)
                        state_r <= ST_CHK;
                    else if (nv_valid_i)
                    begin
                        buf_we_o   <= 1'b1; // see [RQ5]
                        buf_addr_o <= buf_index(base_r, cnt_r);
                        buf_data_o <= nv_data_i;
                        sum_r      <= sum_r + nv_data_i; // see [RQ2]
                        cnt_r      <= cnt_r + 16'h0001;
                        nv_addr_o  <= nv_addr_o + 16'h0001;
                    end
                ST_CHK:
                begin
                    nv_req_o <= 1'b0;
                    state_r  <= ST_IDLE;
                    if ((sum_r[7:0] ^ sum_r[15:8]) != stored_sum_r[7:0])
                        status_o[`STAT_LOAD_ERR] <= 1'b1; // see [RQ2]
                    else
                    begin
                        prog_mode_o <= 1'b1; // see [RQ3]
                        servo_en_o  <= 1'b1;
                        pc_o        <= 16'h0000;
                        pc_load_o   <= 1'b1;
                    end
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// file: plfc_props.sv
`timescale 1ns/1ns
`include "flow_consts.vh"
module plfc_props (
    input wire        clk_i,
    input wire        reset_n_i,
    input wire        cmd_valid_i,
    input wire [7:0]  cmd_code_i,
    input wire        exec_err_i,
    input wire [31:0] reg_data_i,
    input wire [31:0] loop_inc_i,
    input wire [15:0] nv_data_i,
    input wire        nv_valid_i,
    input wire        nv_req_o,
    input wire        buf_we_o,
    input wire [15:0] buf_data_o,
    input wire        reg_we_o,
    input wire [31:0] reg_wdata_o,
    input wire        pc_load_o,
    input wire [15:0] pc_o,
    input wire        prog_mode_o,
    input wire        servo_en_o,
    input wire        ack_o,
    input wire [15:0] status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ack_cause_a: assert property (ack_o |-> $past(cmd_valid_i))
        else $error("ack without command");
    load_req_a: assert property (ack_o && $past(cmd_code_i) == `CMD_LOAD_RUN |-> nv_req_o)
        else $error("load did not request memory");
    loop_sum_a: assert property (reg_we_o |-> ack_o && $past(cmd_code_i) == `CMD_LOOP_CLOSE
        && reg_wdata_o == $past(reg_data_i) + $past(loop_inc_i)) else $error("bad loop sum");
    buf_copy_a: assert property (buf_we_o |-> $past(nv_valid_i) && buf_data_o == $past(nv_data_i))
        else $error("buffer word not copied");
    run_start_a: assert property ($rose(prog_mode_o) |-> pc_load_o && pc_o == 16'h0000)
        else $error("run not from zero");
    load_fail_a: assert property ($rose(status_o[14]) |-> !$rose(prog_mode_o) && !pc_load_o)
        else $error("failed load started");
    err_sticky_a: assert property (status_o[12] |=> status_o[12])
        else $error("error bit dropped");
    exec_stop_a: assert property (exec_err_i && prog_mode_o |->
        ##[1:2] status_o[12] && !prog_mode_o && !servo_en_o) else $error("error did not stop");
    reset_vals_a: assert property (disable iff (1'b0) !reset_n_i |=> servo_en_o && !prog_mode_o
        && !ack_o && status_o == 16'h0000) else $error("bad reset values");
endmodule
bind program_load_flow_control plfc_props u_props (.*);

// file: nv_mem.sv
`timescale 1ns/1ns
module nv_mem (
    input  wire        clk_i,
    input  wire        en_i,
    input  wire [15:0] len_i,
    input  wire        bad_i,
    output reg  [15:0] nv_data_o = 16'h0000,
    output reg         nv_valid_o = 1'b0
);
    reg [15:0] idx_r = 16'h0000;
    reg [1:0]  wait_r = 2'h0;
    reg [15:0] sum;
    reg [15:0] hdr;
    integer    k;
    always @(posedge clk_i)
    begin
        sum = 16'h0000;
        for (k = 0; k < len_i; k = k + 1)
            sum = sum + (16'h3A5C ^ (k[15:0] * 16'h0101));
        hdr = (len_i > 16'h00FE) ? 16'h0002 : 16'h0001;
        wait_r <= en_i ? wait_r + {1'b0, wait_r != 2'h3} : 2'h0;
        if (en_i && wait_r == 2'h3 && !nv_valid_o && idx_r < len_i + hdr)
        begin
            nv_valid_o <= 1'b1;
            idx_r <= idx_r + 16'h0001;
            if (idx_r == 16'h0000)
                nv_data_o <= {hdr[1] ? 8'hFF : len_i[7:0], sum[7:0] ^ sum[15:8] ^ {7'h00, bad_i}};
            else if (idx_r < hdr)
                nv_data_o <= len_i;
            else
                nv_data_o <= 16'h3A5C ^ ((idx_r - hdr) * 16'h0101);
        end
        else
        begin
            // Released bus inverts its word each cycle, so the stale word shows again every other cycle
            nv_valid_o <= 1'b0;
            nv_data_o <= ~nv_data_o;
        end
        if (!en_i)
            idx_r <= 16'h0000;
    end
endmodule

// file: tb_program_load_flow_control.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin num_checks = num_checks + 1; if ((s) !== (e)) begin \
    n_mismatch = n_mismatch + 1; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_program_load_flow_control;
    reg clk_i = 1'b0, reset_n_i = 1'b0, ce_i, cmd_valid_i, cmd_thread_i, ret_i, exec_err_i;
    reg clear_buf_i, nv_other_req_i, bad_r, typ, st, h, br;
    reg [7:0] cmd_code_i;
    reg [3:0] op;
    reg [8:0] base_r;
    reg [15:0] cmd_p0_i, cmd_p1_i, cmd_p4_i, cmd_ret_pc_i, inputs_i, k_r, len_r, a, n;
    reg [31:0] cmd_p2_i, cmd_p3_i, reg_data_i, loop_inc_i, loop_final_i;
    reg signed [31:0] x, y, sum;
    wire [15:0] nv_data_i, nv_addr_o, buf_data_o, pc_o, status_o;
    wire [31:0] reg_wdata_o;
    wire [8:0] buf_addr_o;
    wire nv_valid_i, nv_req_o, buf_we_o, reg_we_o, pc_load_o, prog_mode_o, servo_en_o, ack_o;
    integer n_mismatch = 0, num_checks = 0, seed = 32'hEE49, cyc = 0;
    program_load_flow_control dut (.*);
    nv_mem model (.clk_i(clk_i), .en_i(nv_req_o & ~nv_other_req_i), .len_i(len_r),
                  .bad_i(bad_r), .nv_data_o(nv_data_i), .nv_valid_o(nv_valid_i));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (buf_we_o)
        begin
            `CHK("buf_addr", base_r + k_r[8:0], buf_addr_o)
            `CHK("buf_data", 16'h3A5C ^ (k_r * 16'h0101), buf_data_o)
            k_r = k_r + 16'h0001;
        end
    end
    always @(posedge clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 10000)
        begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    function hit(input [3:0] o, input signed [31:0] r, input signed [31:0] p, input signed [31:0] q);
        hit = o[3] ? ((o[0] ? r < p : r <= p) || (o[1] ? r > q : r >= q))
                   : ((o[0] ? p <= r : p < r) && (o[1] ? r <= q : r < q));
    endfunction
    task results;
    begin
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task rst;
    begin
        reset_n_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        reset_n_i <= 1'b1;
    end
    endtask
    task cmd(input [7:0] c, input [15:0] a0, input [31:0] a2, input [31:0] a3, input [15:0] a4);
    begin
        @(posedge clk_i);
        {cmd_valid_i, cmd_code_i, cmd_p0_i, cmd_p2_i, cmd_p3_i, cmd_p4_i} <= {1'b1, c, a0, a2, a3, a4};
        cmd_ret_pc_i <= 16'($random(seed));
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        @(posedge clk_i);
        `CHK("ack", 1'b1, ack_o)
    end
    endtask
    task call_chk(input hh, input [15:0] t, input r);
    begin
        `CHK("call", hh, pc_load_o)
        if (hh)
            `CHK("target", t, pc_o)
        if (hh && r)
        begin
            ret_i <= 1'b1;
            @(posedge clk_i);
            ret_i <= 1'b0;
            @(posedge clk_i);
            `CHK("ret_load", 1'b1, pc_load_o)
            `CHK("ret_pc", cmd_ret_pc_i, pc_o)
        end
    end
    endtask
    task load(input th, input [15:0] ln, input b, input hold);
        integer w;
        reg [15:0] ad;
    begin
        {len_r, bad_r, nv_other_req_i, cmd_thread_i} <= {ln, b, hold, th};
        k_r = 16'h0000;
        base_r = th ? 9'h100 : 9'h000;
        ad = 16'($random(seed));
        cmd(8'h9C, ad, 32'h0, 32'h0, 16'h0000);
        if (hold)
        begin
            repeat (20) @(posedge clk_i);
            `CHK("held", 16'h0000, k_r)
            nv_other_req_i <= 1'b0;
        end
        for (w = 0; w < 3000 && !pc_load_o && !status_o[14]; w = w + 1)
            @(posedge clk_i);
        `CHK("loaded", ln, k_r)
        `CHK("nv_addr", ad + ln + ((ln > 16'h00FE) ? 16'h0002 : 16'h0001), nv_addr_o)
        `CHK("prog_mode", ~b, prog_mode_o)
        `CHK("load_err", b, status_o[14])
    end
    endtask
    initial
    begin
        {ce_i, cmd_valid_i, cmd_thread_i, ret_i, exec_err_i, clear_buf_i, nv_other_req_i} = 7'h40;
        {cmd_code_i, cmd_p0_i, cmd_p1_i, cmd_p2_i, cmd_p3_i, cmd_p4_i, cmd_ret_pc_i} = '0;
        {inputs_i, reg_data_i, loop_inc_i, loop_final_i, bad_r, len_r} = '0;
        rst;
        load(1'b0, 16'h0005, 1'b1, 1'b1);
        load(1'b0, 16'h00FF, 1'b0, 1'b0);
        load(1'b1, 16'h0001 + {$random(seed)} % 40, 1'b0, 1'b0);
        repeat (8)
        begin
            {reg_data_i, loop_inc_i, loop_final_i} <= {$random(seed) % 64, ($random(seed) % 4) | 1, $random(seed) % 64};
            a = $random(seed);
            cmd(8'hD2, a, 32'h0, 32'h0, 16'h0000);
            sum = reg_data_i + loop_inc_i;
            br = $signed(loop_inc_i) < 0 ? sum >= $signed(loop_final_i) : sum <= $signed(loop_final_i);
            `CHK("wdata", sum, reg_wdata_o)
            call_chk(br, a + 16'h0004, 1'b0);
        end
        repeat (24)
        begin
            {op, typ, x, y, a} = {4'h4 + 4'({$random(seed)} % 8), 1'($random(seed)), $random(seed) % 8, $random(seed) % 8, 16'($random(seed))};
            reg_data_i <= $random(seed) % 8;
            cmd(8'h59, {7'h00, typ, 4'h0, op}, x, y, a);
            call_chk(hit(op, reg_data_i, x, y), a, typ);
        end
        repeat (8)
        begin
            {n, st, a} = {16'h0001 + 16'({$random(seed)} % 14), 1'($random(seed)), 16'($random(seed))};
            {inputs_i, cmd_p1_i} <= {16'($random(seed)), 15'h0000, st};
            cmd(8'hC9, 16'h0000 - n, 32'h0, 32'h0, a);
            call_chk(inputs_i[n] == st, a, 1'b1);
        end
        `CHK("no_error", 1'b0, status_o[12])
        {inputs_i, cmd_p1_i} <= {16'hFFFF, 16'h0001};
        cmd(8'hC9, 16'hFFFF, 32'h0, 32'h0, 16'h0010);
        load(1'b0, 16'h0003, 1'b0, 1'b0);
        cmd(8'hC9, 16'hFFFF, 32'h0, 32'h0, 16'h0010);
        repeat (2) @(posedge clk_i);
        `CHK("stack_cleared", 1'b0, status_o[12])
        cmd(8'hC9, 16'hFFFF, 32'h0, 32'h0, 16'h0010);
        repeat (2) @(posedge clk_i);
        `CHK("nested_err", 2'b10, {status_o[12], prog_mode_o})
        rst;
        load(1'b0, 16'h0004, 1'b0, 1'b0);
        exec_err_i <= 1'b1;
        @(posedge clk_i);
        exec_err_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        `CHK("exec_err", 3'b100, {status_o[12], prog_mode_o, servo_en_o})
        results;
    end
endmodule
